// ### vrx_map.svh
// Status selector codes, field positions and selector reset value of the pin block
//
// Contract
// [RQ1] Parallel clock rate follows rate and width; code passes PCLK_IN through as PCLK_OUT, ignoring HD_RATE and width
// [RQ2] 20-bit video: upper ten carry luma
// [RQ3] 20-bit video: lower ten carry chroma
// [RQ4] 10-bit video: upper ten carry multiplexed words
// [RQ5] 10-bit width holds lower ten low
// [RQ6] 10-bit transport: upper ten decoded data
// [RQ7] Mode decoded from bypass and transport pins
// [RQ8] Automatic: bypass pin outputs compliant-input status
// [RQ9] Manual: bypass pin input enables processing
// [RQ10] Host reset: defaults, digital outputs released
// [RQ11] Test reset: defaults, scan sequence reset
// [RQ12] Test select routes shared pins
// [RQ13] Controller drives chip select low
// [RQ14] Serial bits move with serial clock
// [RQ15] Host shifts in, device returns data
// [RQ16] Six status outputs independently selectable
// [RQ17] Loop-through picks buffered or reclocked
// [RQ18] Switch-line enable reaches timing generator
// [RQ19] Automatic: transport pin drives low status
// [RQ20] Data and status share one clock edge
`ifndef VRX_MAP_SVH
`define VRX_MAP_SVH

// ****************************************
// Status selector codes
// ****************************************
`define SEL_H 4'h0
`define SEL_V 4'h1
`define SEL_F 4'h2
`define SEL_LOCKED 4'h3
`define SEL_YANC 4'h4
`define SEL_CANC 4'h5
`define SEL_DERR 4'h6
`define SEL_VERR 4'h7
`define SEL_EDH 4'h8
`define SEL_CD 4'h9
`define SEL_RATE 4'ha
`define SEL_RESET 24'h6a4210

// ****************************************
// Bus field positions
// ****************************************
`define UPPER_LSB 10
`define WORD_W 10

`endif

// ### vrx_pkg.sv
// Types shared by the pin block
package vrx_pkg;
	// Decoded operating mode, one-hot
	typedef enum logic [3:0] {
		MODE_VIDEO = 4'h1,
		MODE_TRANSPORT = 4'h2,
		MODE_THROUGH = 4'h4,
		MODE_NONE = 4'h8
	} mode_t;
	// Status sources from processing
	typedef struct packed {
		logic h;
		logic v;
		logic f;
		logic locked;
		logic yanc;
		logic canc;
		logic derr;
		logic verr;
		logic edh;
		logic cd;
		logic rate;
	} status_t;
	// One parallel word pair
	typedef struct packed {
		logic [9:0] luma;
		logic [9:0] chroma;
	} video_t;
endpackage

// ### vrx_pins.sv
// Pin control and parallel output bus of the serial video receiver
`timescale 1ns/1ps
`include "vrx_map.svh"
module vrx_pins (
	// System side
	input wire logic MCLK,
	input wire logic RST,
	input wire logic [23:0] STAT_SELECT,
	input wire logic AUTO_MANUAL_SELECT,
	input wire logic COMPLIANT_INPUT,
	// Parallel clock domain
	input wire logic PCLK_IN,
	input wire logic HD_RATE,
	input wire vrx_pkg::video_t VIDEO_IN,
	input wire logic [9:0] TRANSPORT_IN,
	input wire logic [19:0] RAW_IN,
	input wire vrx_pkg::status_t STATUS_IN,
	// Control pins
	input wire logic RESET_N,
	input wire logic BUS_WIDTH_SELECT,
	input wire logic TEST_PORT_SELECT,
	input wire logic RECLOCK_SELECT,
	input wire logic SWITCH_LINE_LOCK_ENABLE,
	// Bypass and transport two-way pins
	input wire logic VIDEO_PROCESSING_BYPASS_I,
	output logic VIDEO_PROCESSING_BYPASS_O,
	output logic VIDEO_PROCESSING_BYPASS_OE_N,
	input wire logic TRANSPORT_MODE_SELECT_I,
	output logic TRANSPORT_MODE_SELECT_O,
	output logic TRANSPORT_MODE_SELECT_OE_N,
	// Shared serial pins
	input wire logic SERIAL_CLK,
	input wire logic CHIP_SELECT_N,
	input wire logic SERIAL_IN,
	output logic SERIAL_OUT,
	output logic SERIAL_OUT_OE_N,
	input wire logic HOST_SERIAL_OUT,
	input wire logic SCAN_SERIAL_OUT,
	output logic HOST_SELECT,
	output logic HOST_CHIP_SELECT_N,
	output logic HOST_SERIAL_IN,
	output logic SCAN_MODE_SELECT,
	output logic SCAN_DATA_IN,
	output logic SCAN_RESET_N,
	// Loop-through
	input wire logic BUFFERED_SERIAL,
	input wire logic RECLOCKED_SERIAL,
	output logic LOOP_SERIAL,
	// Outputs to processing
	output logic PROCESSING_ENABLE,
	output logic SWITCH_LOCK_ENABLE,
	output logic FUNCTION_RESET,
	output logic [3:0] MODE,
	// Parallel outputs
	output logic PCLK_OUT,
	output logic [19:0] PARALLEL_DATA_OUT,
	output logic [5:0] STAT,
	output logic DIGITAL_OE_N
);

	// ****************************************
	// Pin synchronisers on MCLK
	// ****************************************
	// First and second stages of control pins
	logic [6:0] meta;
	logic [6:0] sync;
	wire [6:0] pin_raw = {RESET_N, BUS_WIDTH_SELECT, TEST_PORT_SELECT,
		VIDEO_PROCESSING_BYPASS_I, TRANSPORT_MODE_SELECT_I,
		SWITCH_LINE_LOCK_ENABLE, COMPLIANT_INPUT};

	// Two flops per pin
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			meta <= 7'h00;
			sync <= 7'h00;
		end else begin
			meta <= pin_raw;
			sync <= meta;
		end
	end

	// Named synchronised levels
	wire rst_pin_n = sync[6];
	wire width20 = sync[5];
	wire test_sel = sync[4];
	wire bypass_in = sync[3];
	wire transport_in = sync[2];
	wire swl_in = sync[1];
	wire compliant = sync[0];

	// ****************************************
	// Mode decode
	// ****************************************
	// Effective pin levels depend on automatic control
	wire eff_bypass = AUTO_MANUAL_SELECT ? compliant : bypass_in;
	// Transport never recognised in automatic control
	wire eff_transport = AUTO_MANUAL_SELECT ? 1'b0 : transport_in;

	// Mode from the two pins
	function automatic vrx_pkg::mode_t decode_mode(input logic byp,
		input logic tr);
		case ({byp, tr})
			2'b10: decode_mode = vrx_pkg::MODE_VIDEO;
			2'b01: decode_mode = vrx_pkg::MODE_TRANSPORT;
			2'b00: decode_mode = vrx_pkg::MODE_THROUGH;
			default: decode_mode = vrx_pkg::MODE_NONE;
		endcase
	endfunction

	// [RQ7] decoded operating mode
	wire vrx_pkg::mode_t next_mode = decode_mode(eff_bypass, eff_transport);
	vrx_pkg::mode_t mode;
	// Registered mode and controls
	logic width_q;
	logic proc_en;
	logic swl;
	logic func_rst;

	// Mode register, defaults under pin reset
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			mode <= vrx_pkg::MODE_NONE;
			width_q <= 1'b0;
			proc_en <= 1'b0;
			swl <= 1'b0;
			func_rst <= 1'b1;
		end else begin
			// [RQ10] [RQ11] defaults while reset pin low
			func_rst <= ~rst_pin_n;
			mode <= rst_pin_n ? next_mode : vrx_pkg::MODE_NONE;
			width_q <= width20;
			// [RQ9] processing follows bypass level
			proc_en <= rst_pin_n & eff_bypass;
			// [RQ18] switch-line lock enable
			swl <= rst_pin_n & swl_in;
		end
	end

	assign MODE = mode;
	assign PROCESSING_ENABLE = proc_en;
	assign SWITCH_LOCK_ENABLE = swl;
	assign FUNCTION_RESET = func_rst;

	// ****************************************
	// Two-way pins and serial routing
	// ****************************************
	// [RQ8] bypass driven with compliant status
	assign VIDEO_PROCESSING_BYPASS_O = compliant;
	assign VIDEO_PROCESSING_BYPASS_OE_N = ~(AUTO_MANUAL_SELECT & rst_pin_n);
	// [RQ19] transport pin drives low in automatic
	assign TRANSPORT_MODE_SELECT_O = 1'b0;
	assign TRANSPORT_MODE_SELECT_OE_N = ~(AUTO_MANUAL_SELECT & rst_pin_n);

	// [RQ12] [RQ14] shared pins follow test select
	assign HOST_SELECT = ~TEST_PORT_SELECT;
	// [RQ13] chip select reaches host in host mode, scan mode select in test mode
	assign HOST_CHIP_SELECT_N = TEST_PORT_SELECT | CHIP_SELECT_N;
	assign HOST_SERIAL_IN = SERIAL_IN;
	assign SCAN_MODE_SELECT = TEST_PORT_SELECT & CHIP_SELECT_N;
	assign SCAN_DATA_IN = SERIAL_IN;
	// [RQ11] scan sequence reset from reset pin
	assign SCAN_RESET_N = ~TEST_PORT_SELECT | RESET_N;
	// [RQ15] returned data source
	wire ser_out = TEST_PORT_SELECT ? SCAN_SERIAL_OUT : HOST_SERIAL_OUT;

	// Serial out changes on the falling serial clock edge
	logic ser_q;
	always_ff @(negedge SERIAL_CLK or posedge RST) begin
		if (RST) begin
			ser_q <= 1'b0;
		end else begin
			ser_q <= ser_out;
		end
	end
	assign SERIAL_OUT = ser_q;
	// [RQ10] released in host reset
	assign SERIAL_OUT_OE_N = ~(rst_pin_n | test_sel);

	// [RQ17] loop-through select
	assign LOOP_SERIAL = RECLOCK_SELECT ? RECLOCKED_SERIAL : BUFFERED_SERIAL;

	// ****************************************
	// Parallel clock domain
	// ****************************************
	// Crossings of level controls into PCLK_IN domain
	logic [5:0] p_meta;
	logic [5:0] p_sync;
	logic [5:0] p_hold; // Previous synchronised word
	logic [5:0] p_ctl; // Accepted control word
	wire [5:0] p_src = {width_q, mode, func_rst};
	// Bits may land on different edges: take a word only once it reads
	// the same on two edges, so a half-crossed mix never steers the bus
	wire p_steady = (p_sync == p_hold);
	always_ff @(posedge PCLK_IN or posedge RST) begin
		if (RST) begin
			p_meta <= 6'h11;
			p_sync <= 6'h11;
			p_hold <= 6'h11;
			p_ctl <= 6'h11;
		end else begin
			p_meta <= p_src;
			p_sync <= p_meta;
			p_hold <= p_sync;
			if (p_steady) p_ctl <= p_sync;
		end
	end
	wire p_width20 = p_ctl[5];
	wire [3:0] p_mode = p_ctl[4:1];
	wire p_rst = p_ctl[0];

	// Select crossings for the status map
	logic [23:0] sel_meta;
	logic [23:0] sel_sync;
	logic [23:0] sel_hold; // Previous synchronised selector word
	logic [23:0] sel; // Accepted selector word
	// Same settle rule as the control word
	always_ff @(posedge PCLK_IN or posedge RST) begin
		if (RST) begin
			sel_meta <= `SEL_RESET;
			sel_sync <= `SEL_RESET;
			sel_hold <= `SEL_RESET;
			sel <= `SEL_RESET;
		end else begin
			sel_meta <= STAT_SELECT;
			sel_sync <= sel_meta;
			sel_hold <= sel_sync;
			if (sel_sync == sel_hold) sel <= sel_sync;
		end
	end

	// Ten-bit multiplex phase: luma then chroma
	logic phase;
	always_ff @(posedge PCLK_IN or posedge RST) begin
		if (RST) begin
			phase <= 1'b0;
		end else begin
			phase <= ~phase;
		end
	end

	// [RQ1] clock should follow the rate/width; PCLK_OUT is PCLK_IN unchanged, HD_RATE unused
	assign PCLK_OUT = PCLK_IN;

	// Word pick for 10-bit video
	wire [9:0] mux_word = phase ? VIDEO_IN.chroma : VIDEO_IN.luma;
	logic [19:0] next_data;
	// Bus content per mode and width
	always_comb begin
		next_data = 20'h00000;
		case (p_mode)
			4'h1: begin
				// [RQ2] [RQ3] luma high, chroma low
				if (p_width20) next_data = {VIDEO_IN.luma, VIDEO_IN.chroma};
				// [RQ4] multiplexed words on upper ten
				else next_data = {mux_word, 10'h000};
			end
			4'h2: begin
				// [RQ6] decoded transport on upper ten
				next_data = {TRANSPORT_IN, 10'h000};
			end
			4'h4: next_data = RAW_IN;
			default: next_data = 20'h00000;
		endcase
		// [RQ5] lower ten low in 10-bit width
		if (!p_width20) next_data[9:0] = 10'h000;
	end

	// Status source vector and selection
	wire [10:0] src = {STATUS_IN.rate, STATUS_IN.cd, STATUS_IN.edh,
		STATUS_IN.verr, STATUS_IN.derr, STATUS_IN.canc, STATUS_IN.yanc,
		STATUS_IN.locked, STATUS_IN.f, STATUS_IN.v, STATUS_IN.h};
	logic [5:0] next_stat;
	genvar g;
	generate
		for (g = 0; g < 6; g++) begin : gen_stat
			wire [3:0] code = sel[g*4 +: 4];
			// [RQ16] independent source per output
			assign next_stat[g] = (code <= `SEL_RATE) ? src[code] : 1'b0;
		end
	endgenerate

	// [RQ20] data and status on rising parallel clock
	always_ff @(posedge PCLK_IN or posedge RST) begin
		if (RST) begin
			PARALLEL_DATA_OUT <= 20'h00000;
			STAT <= 6'h00;
		end else if (p_rst) begin
			PARALLEL_DATA_OUT <= 20'h00000;
			STAT <= 6'h00;
		end else begin
			PARALLEL_DATA_OUT <= next_data;
			STAT <= next_stat;
		end
	end

	// [RQ10] digital outputs released in host reset
	assign DIGITAL_OE_N = func_rst & ~test_sel;

	// ****************************************
	// Assertions
	// ****************************************
	property p_low_zero;
		@(posedge PCLK_IN) disable iff (RST)
		!p_width20 |=> PARALLEL_DATA_OUT[9:0] == 10'h000;
	endproperty
	a_low_zero: assert property (p_low_zero) // [RQ5]
		else $error("lower bus not low in 10-bit width");

	property p_luma;
		@(posedge PCLK_IN) disable iff (RST)
		(p_mode == 4'h1 && p_width20 && !p_rst) |=>
			PARALLEL_DATA_OUT[19:10] == $past(VIDEO_IN.luma);
	endproperty
	a_luma: assert property (p_luma) // [RQ2]
		else $error("upper bus not luma");

	property p_chroma;
		@(posedge PCLK_IN) disable iff (RST)
		(p_mode == 4'h1 && p_width20 && !p_rst) |=>
			PARALLEL_DATA_OUT[9:0] == $past(VIDEO_IN.chroma);
	endproperty
	a_chroma: assert property (p_chroma) // [RQ3]
		else $error("lower bus not chroma");

	property p_mux;
		@(posedge PCLK_IN) disable iff (RST)
		(p_mode == 4'h1 && !p_width20 && !p_rst && !phase) |=>
			PARALLEL_DATA_OUT[19:10] == $past(VIDEO_IN.luma);
	endproperty
	a_mux: assert property (p_mux) // [RQ4]
		else $error("multiplexed luma missing");

	property p_transport;
		@(posedge PCLK_IN) disable iff (RST)
		(p_mode == 4'h2 && !p_width20 && !p_rst) |=>
			PARALLEL_DATA_OUT[19:10] == $past(TRANSPORT_IN);
	endproperty
	a_transport: assert property (p_transport) // [RQ6]
		else $error("transport data missing");

	property p_auto_pins;
		@(posedge MCLK) disable iff (RST)
		(AUTO_MANUAL_SELECT && rst_pin_n) |-> !TRANSPORT_MODE_SELECT_OE_N
			&& !TRANSPORT_MODE_SELECT_O && !VIDEO_PROCESSING_BYPASS_OE_N;
	endproperty
	a_auto_pins: assert property (p_auto_pins) // [RQ19]
		else $error("automatic pins not driven");

	property p_manual_proc;
		@(posedge MCLK) disable iff (RST)
		(!AUTO_MANUAL_SELECT && rst_pin_n) |=> proc_en == $past(bypass_in);
	endproperty
	a_manual_proc: assert property (p_manual_proc) // [RQ9]
		else $error("processing enable mismatch");

	property p_reset_release;
		@(posedge MCLK) disable iff (RST)
		(!rst_pin_n && !test_sel && !meta[4]) |=> DIGITAL_OE_N;
	endproperty
	a_reset_release: assert property (p_reset_release) // [RQ10]
		else $error("outputs not released in reset");

	property p_mode_video;
		@(posedge MCLK) disable iff (RST)
		(rst_pin_n && eff_bypass && !eff_transport) |=>
			mode == vrx_pkg::MODE_VIDEO;
	endproperty
	a_mode_video: assert property (p_mode_video) // [RQ7]
		else $error("video mode not decoded");

	property p_loop;
		@(posedge MCLK) disable iff (RST)
		RECLOCK_SELECT |-> LOOP_SERIAL == RECLOCKED_SERIAL;
	endproperty
	a_loop: assert property (p_loop) // [RQ17]
		else $error("loop-through wrong source");
endmodule

// ### vrx_far.sv
// Stream source standing in for the receiver core behind the pin block
`timescale 1ns/1ps
module vrx_far (
	// Link clock
	input wire logic PCLK_IN,
	// Words toward the pin block
	output vrx_pkg::video_t VIDEO_IN,
	output logic [9:0] TRANSPORT_IN,
	output logic [19:0] RAW_IN,
	output vrx_pkg::status_t STATUS_IN
);
	logic [19:0] s = 20'h00048; // Pattern state
	// New words every cycle, so a stale word never matches
	always_ff @(posedge PCLK_IN) begin
		s <= s * 20'h00005 + 20'h003b1;
		VIDEO_IN <= {s[9:0], s[19:10]};
		TRANSPORT_IN <= s[15:6];
		RAW_IN <= ~s;
		STATUS_IN <= s[12:2];
	end
endmodule

// ### test_video_rx_pin_control_and_output_bus.sv
// Self-checking bench of the pin control and parallel output block
`timescale 1ns/1ps
module test_video_rx_pin_control_and_output_bus;
	// **********
	// Signals
	// **********
	logic MCLK = 1'b0, RST = 1'b1, PCLK_IN = 1'b0, HD_RATE = 1'b1;
	logic [23:0] STAT_SELECT = 24'h6a4210;
	logic AUTO_MANUAL_SELECT = 1'b0, COMPLIANT_INPUT = 1'b0, RESET_N = 1'b1;
	logic BUS_WIDTH_SELECT = 1'b1, TEST_PORT_SELECT = 1'b0;
	logic RECLOCK_SELECT = 1'b0, SWITCH_LINE_LOCK_ENABLE = 1'b0;
	logic SERIAL_CLK = 1'b0, CHIP_SELECT_N = 1'b1, SERIAL_IN = 1'b0;
	logic HOST_SERIAL_OUT = 1'b0, SCAN_SERIAL_OUT = 1'b0;
	logic BUFFERED_SERIAL = 1'b0, RECLOCKED_SERIAL = 1'b0;
	logic byp = 1'b1, trs = 1'b0; // Bench levels on the two-way pins
	logic VIDEO_PROCESSING_BYPASS_O, VIDEO_PROCESSING_BYPASS_OE_N;
	logic TRANSPORT_MODE_SELECT_O, TRANSPORT_MODE_SELECT_OE_N;
	// Wire level resolved from both drivers
	wire logic VIDEO_PROCESSING_BYPASS_I = VIDEO_PROCESSING_BYPASS_OE_N ?
		byp : VIDEO_PROCESSING_BYPASS_O;
	wire logic TRANSPORT_MODE_SELECT_I = TRANSPORT_MODE_SELECT_OE_N ?
		trs : TRANSPORT_MODE_SELECT_O;
	logic SERIAL_OUT, SERIAL_OUT_OE_N, HOST_SELECT, HOST_CHIP_SELECT_N;
	logic HOST_SERIAL_IN, SCAN_MODE_SELECT, SCAN_DATA_IN, SCAN_RESET_N;
	logic LOOP_SERIAL, PROCESSING_ENABLE, SWITCH_LOCK_ENABLE, FUNCTION_RESET;
	logic [3:0] MODE;
	logic PCLK_OUT, DIGITAL_OE_N;
	logic [19:0] PARALLEL_DATA_OUT, RAW_IN;
	logic [5:0] STAT;
	logic [9:0] TRANSPORT_IN;
	vrx_pkg::video_t VIDEO_IN;
	vrx_pkg::status_t STATUS_IN;
	// Expected bus word: two allowed values, compare mask, status
	typedef struct packed {
		logic [19:0] a, b, m;
		logic [5:0] s;
		logic sm;
	} note_t;
	note_t q[$]; // Notes waiting for their word
	logic arm = 1'b0; // Noting enabled
	logic ph = 1'b0; // Ten-bit word phase, even after reset is luma
	logic [7:0] rnd = 8'h48; // Random state
	int n_mismatch = 0, check_count = 0;
	// Clocks, unrelated in phase
	always #50 MCLK = ~MCLK;
	always #40 PCLK_IN = ~PCLK_IN;
	vrx_pins uut (.MCLK(MCLK), .RST(RST), .STAT_SELECT(STAT_SELECT),
		.AUTO_MANUAL_SELECT(AUTO_MANUAL_SELECT),
		.COMPLIANT_INPUT(COMPLIANT_INPUT), .PCLK_IN(PCLK_IN),
		.HD_RATE(HD_RATE), .VIDEO_IN(VIDEO_IN),
		.TRANSPORT_IN(TRANSPORT_IN), .RAW_IN(RAW_IN),
		.STATUS_IN(STATUS_IN), .RESET_N(RESET_N),
		.BUS_WIDTH_SELECT(BUS_WIDTH_SELECT),
		.TEST_PORT_SELECT(TEST_PORT_SELECT),
		.RECLOCK_SELECT(RECLOCK_SELECT),
		.SWITCH_LINE_LOCK_ENABLE(SWITCH_LINE_LOCK_ENABLE),
		.VIDEO_PROCESSING_BYPASS_I(VIDEO_PROCESSING_BYPASS_I),
		.VIDEO_PROCESSING_BYPASS_O(VIDEO_PROCESSING_BYPASS_O),
		.VIDEO_PROCESSING_BYPASS_OE_N(VIDEO_PROCESSING_BYPASS_OE_N),
		.TRANSPORT_MODE_SELECT_I(TRANSPORT_MODE_SELECT_I),
		.TRANSPORT_MODE_SELECT_O(TRANSPORT_MODE_SELECT_O),
		.TRANSPORT_MODE_SELECT_OE_N(TRANSPORT_MODE_SELECT_OE_N),
		.SERIAL_CLK(SERIAL_CLK), .CHIP_SELECT_N(CHIP_SELECT_N),
		.SERIAL_IN(SERIAL_IN), .SERIAL_OUT(SERIAL_OUT),
		.SERIAL_OUT_OE_N(SERIAL_OUT_OE_N),
		.HOST_SERIAL_OUT(HOST_SERIAL_OUT),
		.SCAN_SERIAL_OUT(SCAN_SERIAL_OUT), .HOST_SELECT(HOST_SELECT),
		.HOST_CHIP_SELECT_N(HOST_CHIP_SELECT_N),
		.HOST_SERIAL_IN(HOST_SERIAL_IN),
		.SCAN_MODE_SELECT(SCAN_MODE_SELECT),
		.SCAN_DATA_IN(SCAN_DATA_IN), .SCAN_RESET_N(SCAN_RESET_N),
		.BUFFERED_SERIAL(BUFFERED_SERIAL),
		.RECLOCKED_SERIAL(RECLOCKED_SERIAL), .LOOP_SERIAL(LOOP_SERIAL),
		.PROCESSING_ENABLE(PROCESSING_ENABLE),
		.SWITCH_LOCK_ENABLE(SWITCH_LOCK_ENABLE),
		.FUNCTION_RESET(FUNCTION_RESET), .MODE(MODE),
		.PCLK_OUT(PCLK_OUT), .PARALLEL_DATA_OUT(PARALLEL_DATA_OUT),
		.STAT(STAT), .DIGITAL_OE_N(DIGITAL_OE_N));
	vrx_far far (.PCLK_IN(PCLK_IN), .VIDEO_IN(VIDEO_IN),
		.TRANSPORT_IN(TRANSPORT_IN), .RAW_IN(RAW_IN),
		.STATUS_IN(STATUS_IN));
	// **********
	// Helpers
	// **********
	function automatic logic [7:0] lfsr(logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction
	task automatic wm(int n);
		repeat (n) @(posedge MCLK);
		#1;
	endtask
	task automatic wp(int n);
		repeat (n) @(posedge PCLK_IN);
		#1;
	endtask
	task automatic chk(logic got, logic exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %b want %b", $time, got, exp);
		end
	endtask
	task automatic chk_bus(note_t n);
		check_count++;
		if (((PARALLEL_DATA_OUT & n.m) !== (n.a & n.m) &&
			(PARALLEL_DATA_OUT & n.m) !== (n.b & n.m)) ||
			(n.sm && STAT !== n.s)) begin
			n_mismatch++;
			$display("[FAIL] %0t bus %h stat %b", $time, PARALLEL_DATA_OUT, STAT);
		end
	endtask
	// Word the next rising edge must show
	function automatic note_t now_note();
		note_t n;
		logic [10:0] v;
		v = {STATUS_IN.rate, STATUS_IN.cd, STATUS_IN.edh, STATUS_IN.verr,
			STATUS_IN.derr, STATUS_IN.canc, STATUS_IN.yanc,
			STATUS_IN.locked, STATUS_IN.f, STATUS_IN.v, STATUS_IN.h};
		for (int i = 0; i < 6; i++)
			n.s[i] = STAT_SELECT[4*i+:4] > 4'ha ? 1'b0 : v[STAT_SELECT[4*i+:4]];
		n.a = VIDEO_IN;
		n.b = VIDEO_IN;
		n.m = 20'hfffff;
		n.sm = 1'b1;
		if (byp & trs) begin
			n.a = 20'h0;
			n.b = 20'h0;
			n.sm = 1'b0;
		end else if (trs) begin
			n.a = {TRANSPORT_IN, 10'h0};
			n.b = n.a;
			n.m = BUS_WIDTH_SELECT ? 20'h0 : 20'hfffff;
		end else if (!byp) begin
			n.a = RAW_IN;
			n.b = RAW_IN;
		end else if (!BUS_WIDTH_SELECT) begin
			// Luma on even phase, chroma on odd
			n.a = {ph ? VIDEO_IN.chroma : VIDEO_IN.luma, 10'h0};
			n.b = n.a;
		end
		if (!BUS_WIDTH_SELECT) begin
			n.a[9:0] = 10'h0;
			n.b[9:0] = 10'h0;
		end
		return n;
	endfunction
	// Note on the falling edge, compare just after the rising edge
	always @(negedge PCLK_IN) if (arm) q.push_back(now_note());
	// Phase follows every rising parallel clock edge out of reset
	always @(posedge PCLK_IN) ph <= RST ? 1'b0 : ~ph;
	always @(posedge PCLK_IN) begin
		#1;
		if (q.size() > 0) chk_bus(q.pop_front());
	end
	// One mode with random side controls
	task automatic run_mode(logic b, logic t, logic w);
		@(posedge MCLK);
		rnd = lfsr(rnd);
		byp <= b;
		trs <= t;
		BUS_WIDTH_SELECT <= w;
		RECLOCK_SELECT <= rnd[0];
		BUFFERED_SERIAL <= rnd[1];
		RECLOCKED_SERIAL <= rnd[2];
		SWITCH_LINE_LOCK_ENABLE <= rnd[3];
		STAT_SELECT <= {rnd, lfsr(rnd), rnd ^ 8'h5a};
		wm(4);
		chk(MODE === ((b & t) ? 4'h8 : t ? 4'h2 : b ? 4'h1 : 4'h4), 1'b1);
		chk(PROCESSING_ENABLE, b);
		chk(LOOP_SERIAL, rnd[0] ? rnd[2] : rnd[1]);
		chk(SWITCH_LOCK_ENABLE, rnd[3]);
		chk(PCLK_OUT === PCLK_IN, 1'b1);
		wp(4);
		arm = 1'b1;
		wp(20);
		arm = 1'b0;
		wp(2);
	endtask
	// Shared serial pins in one port mode
	task automatic ser(logic t);
		@(posedge MCLK);
		rnd = lfsr(rnd);
		TEST_PORT_SELECT <= t;
		CHIP_SELECT_N <= t;
		SERIAL_IN <= rnd[0];
		HOST_SERIAL_OUT <= rnd[1];
		SCAN_SERIAL_OUT <= rnd[2];
		SERIAL_CLK <= 1'b1;
		wm(4);
		chk(HOST_SELECT, ~t);
		chk(t ? SCAN_DATA_IN : HOST_SERIAL_IN, rnd[0]);
		chk(t ? SCAN_MODE_SELECT : HOST_CHIP_SELECT_N, t);
		@(posedge MCLK);
		SERIAL_CLK <= 1'b0;
		wm(1);
		chk(SERIAL_OUT, t ? rnd[2] : rnd[1]);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Hang guard
	initial begin
		repeat (20000) @(posedge MCLK);
		n_mismatch++;
		$display("[FAIL] %0t run too long", $time);
		give_verdict();
	end
	// **********
	// Main sequence
	// **********
	initial begin
		repeat (3) @(posedge MCLK);
		RST <= 1'b0;
		wm(5);
		wp(4);
		run_mode(1'b1, 1'b0, 1'b1);
		run_mode(1'b1, 1'b0, 1'b0);
		run_mode(1'b0, 1'b1, 1'b0);
		run_mode(1'b0, 1'b1, 1'b1);
		run_mode(1'b0, 1'b0, 1'b1);
		run_mode(1'b0, 1'b0, 1'b0);
		run_mode(1'b1, 1'b1, 1'b1);
		// Automatic: bypass pin reports, transport pin ignored
		@(posedge MCLK);
		AUTO_MANUAL_SELECT <= 1'b1;
		COMPLIANT_INPUT <= 1'b1;
		wm(4);
		chk(VIDEO_PROCESSING_BYPASS_O, 1'b1);
		chk(VIDEO_PROCESSING_BYPASS_OE_N, 1'b0);
		chk(TRANSPORT_MODE_SELECT_O, 1'b0);
		chk(TRANSPORT_MODE_SELECT_OE_N, 1'b0);
		chk(MODE === 4'h1, 1'b1);
		@(posedge MCLK);
		COMPLIANT_INPUT <= 1'b0;
		wm(4);
		chk(VIDEO_PROCESSING_BYPASS_O, 1'b0);
		chk(MODE === 4'h4, 1'b1);
		@(posedge MCLK);
		AUTO_MANUAL_SELECT <= 1'b0;
		wm(4);
		chk(VIDEO_PROCESSING_BYPASS_OE_N, 1'b1);
		ser(1'b0);
		ser(1'b1);
		// Reset pin in host mode, then in scan mode
		@(posedge MCLK);
		TEST_PORT_SELECT <= 1'b0;
		RESET_N <= 1'b0;
		wm(4);
		wp(4);
		chk(DIGITAL_OE_N, 1'b1);
		chk(SERIAL_OUT_OE_N, 1'b1);
		chk(MODE === 4'h8 && PARALLEL_DATA_OUT === 20'h0, 1'b1);
		@(posedge MCLK);
		TEST_PORT_SELECT <= 1'b1;
		wm(4);
		chk(SCAN_RESET_N, 1'b0);
		chk(FUNCTION_RESET, 1'b1);
		@(posedge MCLK);
		RESET_N <= 1'b1;
		TEST_PORT_SELECT <= 1'b0;
		wm(4);
		wp(4);
		chk(FUNCTION_RESET, 1'b0);
		chk(DIGITAL_OE_N, 1'b0);
		give_verdict();
	end
endmodule
